// >>> drsbr_pkg.sv
// Package with the sequencer's register map, encodings and timing constants
package drsbr_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BRK_FREQ = 8'h04;
    localparam logic [7:0] ADDR_STOP_SPD = 8'h08;
    localparam logic [7:0] ADDR_DEMAG = 8'h0C;
    localparam logic [7:0] ADDR_SHORT_HOLD = 8'h10;
    localparam logic [7:0] ADDR_DC_TIME = 8'h14;
    localparam logic [7:0] ADDR_SPD_DELAY = 8'h18;
    localparam logic [7:0] ADDR_DET_TIME = 8'h1C;
    localparam logic [7:0] ADDR_RST_WAIT = 8'h20;
    localparam logic [7:0] ADDR_START_DLY = 8'h24;
    localparam logic [7:0] ADDR_CURRENT = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2C;
    // Control register bit positions and the LSB of the short brake current field
    localparam int CTRL_STOP_MODE = 0;
    localparam int CTRL_DET_MODE = 1;
    localparam int CTRL_RESTART_EN = 2;
    localparam int CTRL_TERM_PROT = 3;
    localparam int CTRL_SW_RUN = 4;
    localparam int CUR_SHORT_LSB = 16;
    // Widths: frequency 0.01 Hz, time 0.01 s, current 0.1 %
    localparam int FREQ_W = 16;
    localparam int TIME_W = 20;
    localparam int CUR_W = 12;
    // Current limits in 0.1 % of rated current
    localparam logic [11:0] DC_CUR_MAX = 12'h3E8;
    localparam logic [11:0] SHORT_CUR_MAX = 12'h5DC;
    // Reset values
    localparam logic [15:0] STOP_SPD_RST = 16'h0032;
    localparam logic [19:0] DET_TIME_RST = 20'h00032;
    localparam logic [19:0] RST_WAIT_RST = 20'h00064;
    // Timebase: one tick per 10 ms at a 20 ns clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_NS = 10_000_000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    // Sequence states
    typedef enum logic [3:0] {
        ST_IDLE, ST_PROTECT, ST_START_WAIT, ST_RUN, ST_DECEL, ST_DEMAG,
        ST_SHORT_BRK, ST_DC_BRK, ST_STOP_DELAY, ST_DET_WAIT, ST_COAST
    } drsbr_state_e;
endpackage

// >>> drsbr_seq.sv
// Stop, braking, stop detection and power-on sequencer of the drive
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - Stop braking only with non-zero start frequency
// - Below brake frequency, wait demagnetization time first
// - Short-circuit brake for hold time, skip if zero
// - DC brake for its time, skip if zero
// - After DC braking, release output to coast
// - Zero threshold: stop-speed delay then determination
// - Set-speed detection mode coasts directly
// - Feedback mode: coast now or after detect time
// - Output blocked during demagnetization interval
// - DC brake current is 0 to 100 percent
// - Short brake current is 0 to 150 percent
// - Restart enable retains running state, any source
// - Retained run resumes after restart wait time
// - Run command waits start delay in standby
// - Protect mode 0 blocks active terminal until re-edge
// - Protect mode 1 starts active terminal after init
// - Decelerate-to-stop lowers frequency along ramp
module drsbr_seq #(
    parameter int P_TICK_CYC = drsbr_pkg::TICK_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rd_data,
    input wire logic i_run_term,
    input wire logic i_init_done,
    input wire logic i_retained_run,
    input wire logic [drsbr_pkg::FREQ_W-1:0] i_ramp_freq,
    input wire logic [drsbr_pkg::FREQ_W-1:0] i_out_freq,
    output logic o_ramp_dec,
    output logic o_out_block,
    output logic o_short_brake,
    output logic o_dc_brake,
    output logic o_run_out,
    output logic [drsbr_pkg::CUR_W-1:0] o_brake_current,
    output logic o_retained_run
);
    import drsbr_pkg::*;
    // Configuration registers
    logic [4:0] ctrl_q;
    logic [FREQ_W-1:0] brk_freq_q, stop_spd_q;
    logic [TIME_W-1:0] demag_q, short_hold_q, dc_time_q, spd_delay_q;
    logic [TIME_W-1:0] det_time_q, rst_wait_q, start_dly_q;
    logic [CUR_W-1:0] dc_cur_q, short_cur_q;
    // Sequence state and helpers
    drsbr_state_e state_q, state_d;
    logic [TIME_W-1:0] tm_q;
    logic [19:0] tick_cnt_q;
    logic tick, tm_done;
    logic [4:0] outs_d; // Output pattern of the next state
    logic term_m_q, term_s_q; // Terminal synchroniser
    logic init_seen_q; // Power-up already handled
    logic restart_q; // Current start came from power-loss restart
    logic run_cmd;
    // Clamp a percentage field to its limit
    function automatic logic [11:0] clamp(input logic [11:0] v,
                                          input logic [11:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction
    // Output pattern {ramp_dec, block, short, dc, run} of a state
    function automatic logic [4:0] outs(input drsbr_state_e s);
        unique case (s)
            ST_RUN: outs = 5'h01;
            ST_DECEL, ST_STOP_DELAY, ST_DET_WAIT: outs = 5'h11;
            ST_SHORT_BRK: outs = 5'h04;
            ST_DC_BRK: outs = 5'h02;
            default: outs = 5'h08;
        endcase
    endfunction
    // Register writes
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= 5'h00;
            brk_freq_q <= 16'h0000;
            stop_spd_q <= STOP_SPD_RST;
            demag_q <= 20'h00000;
            short_hold_q <= 20'h00000;
            dc_time_q <= 20'h00000;
            spd_delay_q <= 20'h00000;
            det_time_q <= DET_TIME_RST;
            rst_wait_q <= RST_WAIT_RST;
            start_dly_q <= 20'h00000;
            dc_cur_q <= 12'h000;
            short_cur_q <= 12'h000;
        end else if (i_wr) begin
            unique case (i_addr)
                ADDR_CTRL: ctrl_q <= i_wr_data[4:0];
                ADDR_BRK_FREQ: brk_freq_q <= i_wr_data[FREQ_W-1:0];
                ADDR_STOP_SPD: stop_spd_q <= i_wr_data[FREQ_W-1:0];
                ADDR_DEMAG: demag_q <= i_wr_data[TIME_W-1:0];
                ADDR_SHORT_HOLD: short_hold_q <= i_wr_data[TIME_W-1:0];
                ADDR_DC_TIME: dc_time_q <= i_wr_data[TIME_W-1:0];
                ADDR_SPD_DELAY: spd_delay_q <= i_wr_data[TIME_W-1:0];
                ADDR_DET_TIME: det_time_q <= i_wr_data[TIME_W-1:0];
                ADDR_RST_WAIT: rst_wait_q <= i_wr_data[TIME_W-1:0];
                ADDR_START_DLY: start_dly_q <= i_wr_data[TIME_W-1:0];
                ADDR_CURRENT: begin
                    // Limits on both setpoints
                    dc_cur_q <= clamp(i_wr_data[CUR_W-1:0], DC_CUR_MAX);
                    short_cur_q <= clamp(
                        i_wr_data[CUR_SHORT_LSB +: CUR_W], SHORT_CUR_MAX);
                end
                default: ;
            endcase
        end
    end
    // Read data valid only in the cycle after the strobe
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data <= 32'h0000_0000;
        end else if (!i_rd) begin
            o_rd_data <= 32'h0000_0000;
        end else begin
            unique case (i_addr)
                ADDR_CTRL: o_rd_data <= {27'h0, ctrl_q};
                ADDR_BRK_FREQ: o_rd_data <= {16'h0, brk_freq_q};
                ADDR_STOP_SPD: o_rd_data <= {16'h0, stop_spd_q};
                ADDR_DEMAG: o_rd_data <= {12'h0, demag_q};
                ADDR_SHORT_HOLD: o_rd_data <= {12'h0, short_hold_q};
                ADDR_DC_TIME: o_rd_data <= {12'h0, dc_time_q};
                ADDR_SPD_DELAY: o_rd_data <= {12'h0, spd_delay_q};
                ADDR_DET_TIME: o_rd_data <= {12'h0, det_time_q};
                ADDR_RST_WAIT: o_rd_data <= {12'h0, rst_wait_q};
                ADDR_START_DLY: o_rd_data <= {12'h0, start_dly_q};
                ADDR_CURRENT: o_rd_data <= {4'h0, short_cur_q, 4'h0, dc_cur_q};
                ADDR_STATUS: o_rd_data <= {24'h0, o_run_out, term_s_q,
                                           restart_q, init_seen_q, state_q};
                default: o_rd_data <= 32'h0000_0000;
            endcase
        end
    end
    // Two-stage synchroniser for the run terminal
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            term_m_q <= 1'b0;
            term_s_q <= 1'b0;
        end else begin
            term_m_q <= i_run_term;
            term_s_q <= term_m_q;
        end
    end
    // Timebase tick divider
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_cnt_q <= 20'h00000;
        end else if (tick) begin
            tick_cnt_q <= 20'h00000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 20'h00001;
        end
    end
    assign tick = (tick_cnt_q == 20'(P_TICK_CYC - 1));
    // Duration of the current state
    function automatic logic [TIME_W-1:0] tgt(input drsbr_state_e s,
                                             input logic rs);
        unique case (s)
            ST_START_WAIT: tgt = rs ? rst_wait_q : start_dly_q;
            ST_DEMAG: tgt = demag_q;
            ST_SHORT_BRK: tgt = short_hold_q;
            ST_DC_BRK: tgt = dc_time_q;
            ST_STOP_DELAY: tgt = spd_delay_q;
            ST_DET_WAIT: tgt = det_time_q;
            default: tgt = '0;
        endcase
    endfunction
    // State timer, cleared on each state entry
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            tm_q <= 20'h00000;
        end else if (state_d != state_q) begin
            tm_q <= 20'h00000;
        end else if (tick && !tm_done) begin
            tm_q <= tm_q + 20'h00001;
        end
    end
    assign tm_done = (tm_q >= tgt(state_q, restart_q));
    // Run from software or a terminal that is not under protection
    assign run_cmd = ctrl_q[CTRL_SW_RUN] ||
                     (term_s_q && state_q != ST_PROTECT);
    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (i_init_done && !init_seen_q) begin
                    // First power-up decision
                    if (ctrl_q[CTRL_RESTART_EN] && i_retained_run) begin
                        state_d = ST_START_WAIT;
                    end else if (term_s_q && !ctrl_q[CTRL_TERM_PROT]) begin
                        state_d = ST_PROTECT;
                    end else if (run_cmd) begin
                        state_d = ST_START_WAIT;
                    end
                end else if (init_seen_q && run_cmd) begin
                    state_d = ST_START_WAIT; // Standby first
                end
            end
            ST_PROTECT: begin
                if (!term_s_q) begin
                    state_d = ST_IDLE; // Needs a fresh edge
                end
            end
            ST_START_WAIT: begin
                if (tm_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!run_cmd) begin
                    state_d = ctrl_q[CTRL_STOP_MODE] ? ST_COAST : ST_DECEL;
                end
            end
            ST_DECEL: begin
                // Braking path only with a threshold
                if (brk_freq_q != '0 && i_ramp_freq < brk_freq_q) begin
                    state_d = ST_DEMAG;
                end else if (brk_freq_q == '0 &&
                             i_ramp_freq < stop_spd_q) begin
                    state_d = ST_STOP_DELAY;
                end
            end
            ST_DEMAG: begin
                if (tm_done) begin
                    if (short_hold_q != '0) begin
                        state_d = ST_SHORT_BRK;
                    end else if (dc_time_q != '0) begin
                        state_d = ST_DC_BRK;
                    end else begin
                        state_d = ST_COAST;
                    end
                end
            end
            ST_SHORT_BRK: begin
                if (tm_done) begin
                    state_d = (dc_time_q != '0) ? ST_DC_BRK : ST_COAST;
                end
            end
            ST_STOP_DELAY: begin
                if (tm_done) begin
                    // Mode bit selects detection
                    if (!ctrl_q[CTRL_DET_MODE] ||
                        i_out_freq < stop_spd_q) begin
                        state_d = ST_COAST;
                    end else begin
                        state_d = ST_DET_WAIT;
                    end
                end
            end
            ST_DC_BRK, ST_DET_WAIT: begin
                if (tm_done) begin
                    state_d = ST_COAST;
                end
            end
            ST_COAST: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end
    // State, power-up bookkeeping and restart origin
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            init_seen_q <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE && i_init_done) begin
                init_seen_q <= 1'b1;
            end
            if (state_q == ST_IDLE) begin
                restart_q <= !init_seen_q && ctrl_q[CTRL_RESTART_EN] &&
                             i_retained_run;
            end
        end
    end
    // Registered outputs decoded from the next state
    assign outs_d = outs(state_d);
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            {o_ramp_dec, o_out_block, o_short_brake, o_dc_brake,
             o_run_out} <= 5'h08;
            o_brake_current <= 12'h000;
            o_retained_run <= 1'b0;
        end else begin
            {o_ramp_dec, o_out_block, o_short_brake, o_dc_brake,
             o_run_out} <= outs_d;
            o_brake_current <= (state_d == ST_SHORT_BRK) ? short_cur_q :
                               (state_d == ST_DC_BRK) ? dc_cur_q : 12'h000;
            // Running state for the store when enabled
            o_retained_run <= ctrl_q[CTRL_RESTART_EN] && outs_d[0];
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence seq_demag_done;
        state_q == ST_DEMAG && tm_done;
    endsequence
    chk_brake_needs_thresh: assert property (
        (o_short_brake || o_dc_brake) |-> brk_freq_q != '0)
        else $error("braking with zero threshold");
    chk_demag_blocks: assert property (
        state_q == ST_DEMAG |-> o_out_block && !o_dc_brake)
        else $error("output not blocked in demag");
    chk_short_skip: assert property (
        seq_demag_done ##0 short_hold_q == '0 |=> state_q != ST_SHORT_BRK)
        else $error("short brake not skipped");
    chk_dc_to_coast: assert property (
        state_q == ST_DC_BRK && tm_done |=> o_out_block ##1 !o_dc_brake)
        else $error("dc brake did not release");
    chk_decel_ramp: assert property (
        state_q == ST_DECEL |-> o_ramp_dec && o_run_out)
        else $error("no ramp during decel");
    chk_protect_hold: assert property (
        state_q == ST_PROTECT && term_s_q |=> !o_run_out)
        else $error("protected terminal started drive");
    chk_setspd_coast: assert property (
        state_q == ST_STOP_DELAY && tm_done && !ctrl_q[CTRL_DET_MODE]
        |=> state_q == ST_COAST)
        else $error("set speed mode did not coast");
    chk_cur_limit: assert property (
        o_brake_current <= SHORT_CUR_MAX &&
        (!o_dc_brake || o_brake_current <= DC_CUR_MAX))
        else $error("brake current out of range");
    chk_start_delay: assert property (
        state_q == ST_START_WAIT && !tm_done |-> !o_run_out)
        else $error("output before start delay");
    chk_timer_clear: assert property (
        state_q != $past(state_q) |-> tm_q == '0)
        else $error("timer not cleared on entry");
endmodule // drsbr_seq

// >>> drsbr_plant.sv
// Ramp and power stage stand-in facing the stop sequencer
`timescale 1ns/1ps
module drsbr_plant (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ramp_dec,
    input wire logic i_run_out,
    input wire logic [15:0] i_lag,
    output logic [15:0] o_ramp_freq,
    output logic [15:0] o_out_freq
);
    // Ramp falls 0.5 Hz a cycle on request, climbs to 50 Hz when running
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ramp_freq <= 16'h0000;
        end else if (i_ramp_dec) begin
            o_ramp_freq <= (o_ramp_freq > 16'h0032) ?
                o_ramp_freq - 16'h0032 : 16'h0000;
        end else if (i_run_out) begin
            o_ramp_freq <= (o_ramp_freq < 16'h1388) ?
                o_ramp_freq + 16'h0064 : 16'h1388;
        end
    end
    // Feedback exceeds the ramp by a slip the bench chooses
    assign o_out_freq = o_ramp_freq + i_lag;
endmodule // drsbr_plant

// >>> drsbr_seq_tb.sv
// Self-checking bench for the stop and power-on sequencer
`timescale 1ns/1ps
module drsbr_seq_tb;
    import drsbr_pkg::*;
    localparam int PT = 4; // Short tick for simulation
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic term = 1'b0;
    logic init = 1'b0;
    logic ret = 1'b0;
    logic [15:0] lag = 16'h0000;
    logic [31:0] rdat;
    logic [15:0] rfq, ofq;
    logic dec, blk, shb, dcb, run, ret_o;
    logic [11:0] cur;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int n; // Cycles counted by span
    logic seen; // Any brake seen during span
    always #10 clk = ~clk;
    drsbr_seq #(.P_TICK_CYC(PT)) drsbr_seq_inst (
        .i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wd),
        .i_wr(wr), .i_rd(rd), .o_rd_data(rdat), .i_run_term(term),
        .i_init_done(init), .i_retained_run(ret), .i_ramp_freq(rfq),
        .i_out_freq(ofq), .o_ramp_dec(dec), .o_out_block(blk),
        .o_short_brake(shb), .o_dc_brake(dcb), .o_run_out(run),
        .o_brake_current(cur), .o_retained_run(ret_o));
    drsbr_plant drsbr_plant_inst (
        .i_ref_clk(clk), .i_rst(rst), .i_ramp_dec(dec), .i_run_out(run),
        .i_lag(lag), .o_ramp_freq(rfq), .o_out_freq(ofq));
    // Verdict and end of run
    task automatic results();
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Value compare
    task automatic cmp(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    // Duration compare in cycles
    task automatic cmp_rng(input string s, input int lo, input int hi,
                           input int g);
        n_checks++;
        if (g < lo || g > hi) begin
            n_errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", s, lo, hi, g);
        end
    endtask
    // One-cycle register write
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read, data judged in the single cycle it stands
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string s);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(s, e, rdat);
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: sig = run;
            1: sig = blk;
            2: sig = shb;
            3: sig = dcb;
            default: sig = dec;
        endcase
    endfunction
    // Count cycles while output k holds level l, bounded by lim
    task automatic span(input int k, input logic l, input int lim);
        n = 0;
        seen = 1'b0;
        while (sig(k) === l && n < lim) begin
            @(posedge clk);
            #1;
            n++;
            seen = seen | shb | dcb;
        end
    endtask
    task automatic power_up(input logic r, input logic t);
        rst <= 1'b1;
        init <= 1'b0;
        ret <= r;
        term <= t;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
    endtask
    // Run up to full ramp, then drop the terminal
    task automatic go_stop();
        term <= 1'b1;
        span(0, 1'b0, 80);
        while (rfq !== 16'h1388 && n < 400) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        term <= 1'b0;
    endtask
    task automatic t_protect0();
        power_up(1'b0, 1'b1);
        rchk(ADDR_STOP_SPD, 32'h0000_0032, "stop speed");
        rchk(ADDR_DET_TIME, 32'h0000_0032, "detect time");
        rchk(ADDR_RST_WAIT, 32'h0000_0064, "restart wait");
        wr_reg(8'h30, 32'hFFFF_FFFF);
        rchk(8'h30, 32'h0, "unmapped");
        wr_reg(ADDR_CURRENT, 32'hFFFF_FFFF);
        rchk(ADDR_CURRENT, 32'h05DC_03E8, "current clamp");
        wr_reg(ADDR_START_DLY, 32'h2);
        init <= 1'b1;
        span(0, 1'b0, 60);
        cmp_rng("protected run", 60, 60, n);
        @(posedge clk);
        term <= 1'b0;
        repeat (10) @(posedge clk);
        term <= 1'b1;
        span(0, 1'b0, 60);
        cmp_rng("start delay", 8, 20, n);
    endtask
    task automatic t_brake();
        wr_reg(ADDR_BRK_FREQ, 32'h3E8);
        wr_reg(ADDR_DEMAG, 32'h2);
        wr_reg(ADDR_SHORT_HOLD, 32'h3);
        wr_reg(ADDR_DC_TIME, 32'h2);
        wr_reg(ADDR_CURRENT, 32'h0200_0100);
        go_stop();
        span(4, 1'b0, 20);
        cmp("decel request", 1'b1, dec);
        span(1, 1'b0, 200);
        cmp("below brake freq", 1'b1, rfq < 16'h03E8);
        cmp("blocked in demag", 3'b100, {blk, run, shb});
        span(1, 1'b1, 60);
        cmp_rng("demag time", 5, 14, n);
        cmp("short brake", 13'h1200, {shb, cur});
        span(2, 1'b1, 60);
        cmp_rng("short hold", 9, 18, n);
        cmp("dc brake", 13'h1100, {dcb, cur});
        span(3, 1'b1, 60);
        cmp_rng("dc time", 5, 14, n);
        cmp("coast", 3'b100, {blk, shb, dcb});
    endtask
    task automatic t_skip();
        wr_reg(ADDR_SHORT_HOLD, 32'h0);
        wr_reg(ADDR_DC_TIME, 32'h0);
        go_stop();
        span(1, 1'b0, 300);
        span(1, 1'b1, 60);
        cmp("no brake stage", 1'b0, seen);
        cmp_rng("blocked to idle", 60, 60, n);
    endtask
    // Zero brake threshold: time from ramp below stop speed to coast
    task automatic t_det(input logic [31:0] c, input logic [15:0] l,
                         input int lo, input int hi);
        wr_reg(ADDR_CTRL, c);
        lag <= l;
        go_stop();
        n = 0;
        while (rfq >= 16'h0032 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        span(1, 1'b0, 80);
        cmp_rng("stop determination", lo, hi, n);
        cmp("no brake zero freq", 1'b0, seen);
    endtask
    // Coast stop mode with software run: output released at once
    task automatic t_coast();
        wr_reg(ADDR_CTRL, 32'h11);
        span(0, 1'b0, 80);
        rchk(ADDR_STATUS, 32'h0000_0093, "status run");
        wr_reg(ADDR_CTRL, 32'h1);
        span(1, 1'b0, 10);
        cmp_rng("coast delay", 1, 2, n);
        cmp("coast no ramp", 2'b00, {dec, run});
    endtask
    task automatic t_restart();
        @(posedge clk);
        power_up(1'b1, 1'b1);
        wr_reg(ADDR_CTRL, 32'hC); // Restart on, terminal valid
        wr_reg(ADDR_RST_WAIT, 32'h3);
        wr_reg(ADDR_START_DLY, 32'hA);
        init <= 1'b1;
        span(0, 1'b0, 100);
        cmp_rng("restart wait", 8, 20, n);
        repeat (2) @(posedge clk);
        #1 cmp("retained run", 1'b1, ret_o);
    endtask
    task automatic t_protect1();
        @(posedge clk);
        power_up(1'b0, 1'b1);
        wr_reg(ADDR_CTRL, 32'h8);
        init <= 1'b1;
        span(0, 1'b0, 100);
        cmp_rng("auto start", 1, 10, n);
        repeat (2) @(posedge clk);
        #1 cmp("retained off", 1'b0, ret_o);
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        t_protect0();
        t_brake();
        t_skip();
        wr_reg(ADDR_BRK_FREQ, 32'h0);
        wr_reg(ADDR_SPD_DELAY, 32'h3);
        wr_reg(ADDR_DET_TIME, 32'h5);
        t_det(32'h0, 16'h0100, 6, 20);
        t_det(32'h2, 16'h0000, 6, 20);
        t_det(32'h2, 16'h0100, 22, 44);
        t_coast();
        t_restart();
        t_protect1();
        results();
    end
endmodule // drsbr_seq_tb
